// [rtl/slw_pkg.sv]
// Package for the second-level page walker: register map, entry fields,
// walk states and bus carriers.
// Assumes a 32-bit APB master and a 64-bit single-beat table read port.
package slw_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ROOT_LO  = 8'h04;
  localparam logic [7:0] REG_ROOT_HI  = 8'h08;
  localparam logic [7:0] REG_CAP      = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_RESULT_LO = 8'h14;
  localparam logic [7:0] REG_RESULT_HI = 8'h18;

  // Control fields
  localparam int CTRL_DWIDTH_LSB = 0;   // domain_input_width, 6 bits
  localparam int CTRL_DWIDTH_W   = 6;
  localparam logic [5:0] DWIDTH_RST = 6'h27;  // 39 bits

  // Capability fields (read only)
  localparam int CAP_MAXW_LSB  = 0;     // max_input_width, 6 bits
  localparam int CAP_HOSTW_LSB = 8;     // host_width, 6 bits
  localparam int CAP_1G_BIT    = 16;
  localparam int CAP_2M_BIT    = 17;
  localparam int CAP_COH_BIT   = 18;
  localparam int CAP_ETLB_BIT  = 19;

  // Status fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_DONE_BIT  = 1;
  localparam int ST_FAULT_BIT = 2;
  localparam int ST_PERM_BIT  = 3;
  localparam int ST_SIZE_LSB  = 4;      // 2 bits: 0 4K, 1 2M, 2 1G

  // Entry bit positions
  localparam int ENT_LOAD   = 0;
  localparam int ENT_STORE  = 1;
  localparam int ENT_BIG    = 7;
  localparam int ENT_FCOH   = 11;
  localparam int ENT_TRANS  = 62;
  localparam int ENT_ADDR_MSB = 51;

  // Address geometry
  localparam int PG_SHIFT   = 12;
  localparam int STRIDE     = 9;
  localparam int L2_SHIFT   = 21;
  localparam int L3_SHIFT   = 30;
  localparam int L4_SHIFT   = 39;
  localparam int L5_SHIFT   = 48;
  localparam int L5_MSB     = 56;
  localparam logic [5:0] WIDTH_3LVL = 6'h27;  // 39
  localparam logic [5:0] WIDTH_4LVL = 6'h30;  // 48
  localparam logic [5:0] WIDTH_5LVL = 6'h39;  // 57

  localparam logic [1:0] SIZE_4K = 2'h0;
  localparam logic [1:0] SIZE_2M = 2'h1;
  localparam logic [1:0] SIZE_1G = 2'h2;

  localparam logic [2:0] LVL_1 = 3'h1;
  localparam logic [2:0] LVL_2 = 3'h2;
  localparam logic [2:0] LVL_3 = 3'h3;
  localparam logic [2:0] LVL_4 = 3'h4;
  localparam logic [2:0] LVL_5 = 3'h5;

  typedef enum logic [1:0] {
    SLW_IDLE  = 2'b00,
    SLW_FETCH = 2'b01,
    SLW_WAIT  = 2'b11,
    SLW_DONE  = 2'b10
  } slw_state_t;

  // Request kinds
  localparam logic [1:0] REQ_READ  = 2'h0;
  localparam logic [1:0] REQ_WRITE = 2'h1;
  localparam logic [1:0] REQ_ATOM  = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [63:0] addr;
  } slw_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;   // no valid translation
    logic        denied;  // valid translation, access refused
    logic [1:0]  size;
    logic [63:0] addr;
  } slw_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [51:0] addr;
  } slw_mrd_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [63:0] data;
  } slw_mrsp_t;

endpackage : slw_pkg

// [rtl/slw_walker.sv]
// Second-level page walker: untagged DMA address translation.
// Assumes one outstanding table read; the memory answers with one beat.
// Overview of operation
// - Input address beyond maximum supported width faults at once.
// - Adjusted width rounds domain width so width minus 12 divides by 9.
// - 4K pages always; 2M and 1G pages advertised by capability.
// - Entry address: zero low three bits, nine index bits, table base above.
// - Five-level walk starts at root, indexed by top bits down to 48.
// - Level four base from level five entry or root; bits 47:39.
// - Level three base from level four entry or root; bits 38:30.
// - Level three big page ends walk with a 1G mapping.
// - Level three without big page continues with bits 29:21.
// - Level two big page ends walk with a 2M mapping.
// - Level two without big page continues into leaf, bits 20:12.
// - Leaf entry maps a 4K page; low twelve bits from input.
// - Entry with no access or a reserved bit set causes error.
// - Address bits from 51 down to host width are reserved.
// - Big page flag reserved at levels five and four.
// - Big page flag reserved where that page size is unsupported.
// - Low address bits of large page entries are reserved.
// - Coherence and transient fields reserved in non-leaf entries.
// - Leaf coherence and transient fields reserved without capability.
// - Fetch permission bit ignored for untagged requests.
// - Reads need load, writes store, atomics both, in every entry.
// - Table read error means no valid translation.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module slw_walker #(
  parameter logic [5:0] MAX_WIDTH  = 6'h30,
  parameter logic [5:0] HOST_WIDTH = 6'h2e,
  parameter logic       HAS_1G     = 1'b1,
  parameter logic       HAS_2M     = 1'b1,
  parameter logic       HAS_COH    = 1'b1,
  parameter logic       HAS_ETLB   = 1'b0
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Translation request and answer
  input  wire slw_pkg::slw_req_t req,
  output logic                   req_ready,
  output slw_pkg::slw_rsp_t      rsp,
  // Table read port
  output slw_pkg::slw_mrd_t      mrd,
  input  wire slw_pkg::slw_mrsp_t mrsp
);

  // Software registers
  logic [5:0]  dwidth_r;
  logic [51:0] root_r;
  logic [1:0]  size_r;
  logic        done_r, fault_r, perm_r;
  logic [63:0] res_r;

  // Walk state
  slw_pkg::slw_state_t state_r, state_nxt;
  logic [2:0]  lvl_r;
  logic [63:0] ia_r;
  logic [1:0]  kind_r;
  logic        ok_ld_r, ok_st_r;

  wire [5:0] adj_width = (dwidth_r <= slw_pkg::WIDTH_3LVL) ?
                         slw_pkg::WIDTH_3LVL :
                         (dwidth_r <= slw_pkg::WIDTH_4LVL) ?
                         slw_pkg::WIDTH_4LVL : slw_pkg::WIDTH_5LVL;
  wire [2:0] top_lvl = (adj_width == slw_pkg::WIDTH_3LVL) ? slw_pkg::LVL_3 :
                       (adj_width == slw_pkg::WIDTH_4LVL) ? slw_pkg::LVL_4 :
                       slw_pkg::LVL_5;
  // Effective limit: smaller of maximum and adjusted width
  wire [5:0] lim_width = (MAX_WIDTH < adj_width) ? MAX_WIDTH : adj_width;

  // out-of-range check on the incoming address
  logic [63:0] lim_mask;
  assign lim_mask = ~((64'h1 << lim_width) - 64'h1);
  wire in_range = (req.addr & lim_mask) == 64'h0;

  // Current entry fields
  wire [63:0] ent    = mrsp.data;
  wire        e_ld   = ent[slw_pkg::ENT_LOAD];
  wire        e_st   = ent[slw_pkg::ENT_STORE];
  wire        e_big  = ent[slw_pkg::ENT_BIG];
  wire        e_live = e_ld | e_st;
  wire [51:0] e_base = {ent[slw_pkg::ENT_ADDR_MSB:slw_pkg::PG_SHIFT],
                        12'h000};

  // bits above host width; one bit per position, one generate
  logic [51:0] hw_mask;
  genvar gi;
  generate
    for (gi = 0; gi < 52; gi++) begin : g_hw
      assign hw_mask[gi] = (gi >= HOST_WIDTH);
    end
  endgenerate
  wire rsv_host = |(ent[51:0] & hw_mask);

  // Level classification of this entry
  wire upper_lvl = (lvl_r == slw_pkg::LVL_5) || (lvl_r == slw_pkg::LVL_4);
  wire is_1g   = (lvl_r == slw_pkg::LVL_3) && e_big;
  wire is_2m   = (lvl_r == slw_pkg::LVL_2) && e_big;
  wire is_leaf = (lvl_r == slw_pkg::LVL_1) || is_1g || is_2m;

  // Reserved checks, applied to every fetched entry whether or not it grants access
  localparam int L3M = slw_pkg::L3_SHIFT - 1;
  localparam int L2M = slw_pkg::L2_SHIFT - 1;
  wire rsv_big = upper_lvl && e_big;
  wire rsv_nosz = (is_1g && !HAS_1G) || (is_2m && !HAS_2M);
  wire rsv_low = (is_1g && (|ent[L3M:slw_pkg::PG_SHIFT])) ||
                 (is_2m && (|ent[L2M:slw_pkg::PG_SHIFT]));
  wire rsv_nl  = !is_leaf && (ent[slw_pkg::ENT_FCOH] ||
                 ent[slw_pkg::ENT_TRANS]);
  wire rsv_lf  = is_leaf && ((ent[slw_pkg::ENT_FCOH] && !HAS_COH) ||
                 (ent[slw_pkg::ENT_TRANS] && !HAS_ETLB));
  // unusable entry; fetch bit never looked at
  wire bad_ent = !e_live || rsv_host || rsv_big || rsv_nosz ||
                 rsv_low || rsv_nl || rsv_lf;

  wire nl_ld = ok_ld_r & e_ld;
  wire nl_st = ok_st_r & e_st;
  wire allowed = (kind_r == slw_pkg::REQ_READ)  ? nl_ld :
                 (kind_r == slw_pkg::REQ_WRITE) ? nl_st : (nl_ld & nl_st);

  // Index for the current level
  logic [8:0] idx;
  always_comb begin
    case (lvl_r)
      slw_pkg::LVL_5: idx = ia_r[slw_pkg::L5_MSB:slw_pkg::L5_SHIFT];
      slw_pkg::LVL_4: idx = ia_r[slw_pkg::L5_SHIFT-1:slw_pkg::L4_SHIFT];
      slw_pkg::LVL_3: idx = ia_r[slw_pkg::L4_SHIFT-1:slw_pkg::L3_SHIFT];
      slw_pkg::LVL_2: idx = ia_r[slw_pkg::L3_SHIFT-1:slw_pkg::L2_SHIFT];
      default:        idx = ia_r[slw_pkg::L2_SHIFT-1:slw_pkg::PG_SHIFT];
    endcase
  end
  // Bits above range are zero by the width check, so the top slice
  // naturally acts as "max width down to shift"

  // Table base register: root first, then each entry's next_base
  logic [51:0] tbase_r;
  wire [51:0] fetch_addr = {tbase_r[51:slw_pkg::PG_SHIFT], idx, 3'h0};

  // Output address per mapping size
  wire [63:0] map_1g = {12'h000, e_base[51:slw_pkg::L3_SHIFT],
                        ia_r[L3M:0]};
  wire [63:0] map_2m = {12'h000, e_base[51:slw_pkg::L2_SHIFT],
                        ia_r[L2M:0]};
  wire [63:0] map_4k = {12'h000, e_base[51:slw_pkg::PG_SHIFT],
                        ia_r[slw_pkg::PG_SHIFT-1:0]};

  wire start = req.valid && req_ready;
  wire got   = (state_r == slw_pkg::SLW_WAIT) && mrsp.valid;

  // APB access decode, needed by the done clear below
  wire apb_acc = psel && penable;
  wire apb_wr  = apb_acc && pwrite;
  wire busy    = state_r != slw_pkg::SLW_IDLE;

  // State machine
  always_comb begin
    case (state_r)
      slw_pkg::SLW_IDLE:  state_nxt = start ? (in_range ? slw_pkg::SLW_FETCH
                                     : slw_pkg::SLW_DONE) : slw_pkg::SLW_IDLE;
      slw_pkg::SLW_FETCH: state_nxt = slw_pkg::SLW_WAIT;
      slw_pkg::SLW_WAIT:  state_nxt = !got ? slw_pkg::SLW_WAIT :
                          (mrsp.error || bad_ent || is_leaf) ?
                          slw_pkg::SLW_DONE : slw_pkg::SLW_FETCH;
      slw_pkg::SLW_DONE:  state_nxt = slw_pkg::SLW_IDLE;
      default:            state_nxt = slw_pkg::SLW_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) state_r <= slw_pkg::SLW_IDLE;
    else       state_r <= state_nxt;
  end

  // Walk registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lvl_r   <= slw_pkg::LVL_1;
      ia_r    <= 64'h0;
      kind_r  <= slw_pkg::REQ_READ;
      ok_ld_r <= 1'b0;
      ok_st_r <= 1'b0;
      tbase_r <= 52'h0;
    end else if (start) begin
      lvl_r   <= top_lvl;
      ia_r    <= req.addr;
      kind_r  <= req.kind;
      ok_ld_r <= 1'b1;
      ok_st_r <= 1'b1;
      tbase_r <= root_r;
    end else if (got) begin
      lvl_r   <= lvl_r - 3'h1;
      ok_ld_r <= nl_ld;
      ok_st_r <= nl_st;
      tbase_r <= e_base;
    end
  end

  // Result registers and answer pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rsp     <= '0;
      res_r   <= 64'h0;
      size_r  <= slw_pkg::SIZE_4K;
      fault_r <= 1'b0;
      perm_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      rsp.valid <= 1'b0;
      if (start && !in_range) begin
        rsp     <= '{valid: 1'b1, fault: 1'b1, denied: 1'b0,
                     size: slw_pkg::SIZE_4K, addr: 64'h0};
        fault_r <= 1'b1;
        perm_r  <= 1'b0;
        res_r   <= 64'h0;
        done_r  <= 1'b1;
      end else if (got && (mrsp.error || bad_ent)) begin
        rsp     <= '{valid: 1'b1, fault: 1'b1, denied: 1'b0,
                     size: slw_pkg::SIZE_4K, addr: 64'h0};
        fault_r <= 1'b1;
        perm_r  <= 1'b0;
        res_r   <= 64'h0;
        done_r  <= 1'b1;
      end else if (got && is_leaf) begin
        rsp.valid  <= 1'b1;
        rsp.fault  <= 1'b0;
        rsp.denied <= !allowed;
        rsp.size   <= is_1g ? slw_pkg::SIZE_1G :
                      is_2m ? slw_pkg::SIZE_2M : slw_pkg::SIZE_4K;
        rsp.addr   <= is_1g ? map_1g : is_2m ? map_2m : map_4k;
        res_r      <= is_1g ? map_1g : is_2m ? map_2m : map_4k;
        size_r     <= is_1g ? slw_pkg::SIZE_1G :
                      is_2m ? slw_pkg::SIZE_2M : slw_pkg::SIZE_4K;
        fault_r    <= 1'b0;
        perm_r     <= !allowed;
        done_r     <= 1'b1;
      end else if (apb_wr && (paddr == slw_pkg::REG_STATUS) &&
                   pwdata[slw_pkg::ST_DONE_BIT]) begin
        done_r <= 1'b0;  // Set above wins over this clear
      end
    end
  end

  // Table read port and request handshake
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mrd       <= '0;
      req_ready <= 1'b0;
    end else begin
      if (state_r == slw_pkg::SLW_FETCH) begin
        mrd.valid <= 1'b1;
        mrd.addr  <= fetch_addr;
      end else begin
        mrd.valid <= 1'b0;
      end
      req_ready <= (state_nxt == slw_pkg::SLW_IDLE) && !start;
    end
  end

  // APB slave, zero wait states
  wire [31:0] cap_word = {12'h000, HAS_ETLB, HAS_COH, HAS_2M, HAS_1G,
                          2'h0, HOST_WIDTH, 2'h0, MAX_WIDTH};
  wire [31:0] st_word  = {26'h0, size_r, perm_r, fault_r, done_r, busy};
  wire known = (paddr == slw_pkg::REG_CTRL) ||
               (paddr == slw_pkg::REG_ROOT_LO) ||
               (paddr == slw_pkg::REG_ROOT_HI) ||
               (paddr == slw_pkg::REG_CAP) ||
               (paddr == slw_pkg::REG_STATUS) ||
               (paddr == slw_pkg::REG_RESULT_LO) ||
               (paddr == slw_pkg::REG_RESULT_HI);
  wire [31:0] rd_mux =
    (paddr == slw_pkg::REG_CTRL)      ? {26'h0, dwidth_r} :
    (paddr == slw_pkg::REG_ROOT_LO)   ? root_r[31:0] :
    (paddr == slw_pkg::REG_ROOT_HI)   ? {12'h000, root_r[51:32]} :
    (paddr == slw_pkg::REG_CAP)       ? cap_word :
    (paddr == slw_pkg::REG_STATUS)    ? st_word :
    (paddr == slw_pkg::REG_RESULT_LO) ? res_r[31:0] :
    (paddr == slw_pkg::REG_RESULT_HI) ? res_r[63:32] : 32'h0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dwidth_r <= slw_pkg::DWIDTH_RST;
      root_r   <= 52'h0;
    end else if (apb_wr && !busy) begin
      // Walk inputs frozen while a walk runs
      if (paddr == slw_pkg::REG_CTRL)
        dwidth_r <= pwdata[5:0];
      if (paddr == slw_pkg::REG_ROOT_LO)
        root_r[31:0] <= {pwdata[31:slw_pkg::PG_SHIFT], 12'h000};
      if (paddr == slw_pkg::REG_ROOT_HI)
        root_r[51:32] <= pwdata[19:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // Assertions
  a_range_fault: assert property (@(posedge clk_sys) disable iff (reset)
    (start && !in_range) |=> (rsp.valid && rsp.fault))
    else $error("Out of range address not faulted");

  a_fetch_order: assert property (@(posedge clk_sys) disable iff (reset)
    got && !mrsp.error && !bad_ent && !is_leaf
      |=> lvl_r == $past(lvl_r) - 3'h1)
    else $error("Walk skipped a level");

  a_single_read: assert property (@(posedge clk_sys) disable iff (reset)
    mrd.valid |=> !mrd.valid)
    else $error("Second table read issued back to back");

  a_bad_entry: assert property (@(posedge clk_sys) disable iff (reset)
    got && bad_ent |=> rsp.valid && rsp.fault)
    else $error("Unusable entry did not fault");

  a_read_error: assert property (@(posedge clk_sys) disable iff (reset)
    got && mrsp.error |=> rsp.valid && rsp.fault)
    else $error("Table read error not faulted");

  a_leaf_4k: assert property (@(posedge clk_sys) disable iff (reset)
    got && !bad_ent && !mrsp.error && lvl_r == slw_pkg::LVL_1
      |=> rsp.valid && rsp.size == slw_pkg::SIZE_4K &&
          rsp.addr[11:0] == $past(ia_r[11:0]))
    else $error("Leaf mapping wrong");

  a_map_2m: assert property (@(posedge clk_sys) disable iff (reset)
    got && !bad_ent && !mrsp.error && is_2m
      |=> rsp.valid && rsp.size == slw_pkg::SIZE_2M &&
          rsp.addr[L2M:0] == $past(ia_r[L2M:0]))
    else $error("Two megabyte mapping wrong");

  a_map_1g: assert property (@(posedge clk_sys) disable iff (reset)
    got && !bad_ent && !mrsp.error && is_1g
      |=> rsp.valid && rsp.size == slw_pkg::SIZE_1G &&
          rsp.addr[L3M:0] == $past(ia_r[L3M:0]))
    else $error("One gigabyte mapping wrong");

  // One answer per walk; a held valid would double count a request
  a_rsp_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    rsp.valid |=> !rsp.valid)
    else $error("Answer valid longer than one cycle");

  a_big_upper: assert property (@(posedge clk_sys) disable iff (reset)
    got && upper_lvl && e_live && e_big
      |=> rsp.valid && rsp.fault)
    else $error("Big flag at upper level accepted");

  a_root_start: assert property (@(posedge clk_sys) disable iff (reset)
    start && in_range |=> ##1 mrd.valid &&
      mrd.addr[51:12] == $past(root_r[51:12], 2))
    else $error("Walk did not start at root");

endmodule : slw_walker

`default_nettype wire

// [bench/slw_mem_model.sv]
// Table memory model: one read at a time, answered after lat cycles.
// Assumes the walker holds mrd.addr until its next read.
`timescale 1ns/100ps
`default_nettype none

module slw_mem_model (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // Read port
  input  wire slw_pkg::slw_mrd_t  mrd,
  output slw_pkg::slw_mrsp_t      mrsp,
  // Bench control
  input  wire logic [3:0]         lat,
  input  wire logic [51:0]        err_addr
);
  logic [63:0] tbl [logic [51:0]];
  logic [51:0] seen [$];
  logic [63:0] last;

  always @(posedge clk_sys) begin
    if (reset === 1'b1) begin
      mrsp <= '0;
    end else if (mrd.valid === 1'b1) begin
      seen.push_back(mrd.addr);
      repeat (lat) @(posedge clk_sys);
      // Missing entries read as zero, i.e. not present
      last = tbl.exists(mrd.addr) ? tbl[mrd.addr] : 64'h0;
      mrsp <= '{valid: 1'b1, error: mrd.addr == err_addr, data: last};
      @(posedge clk_sys);
      // Data is not held after the beat
      mrsp <= '{valid: 1'b0, error: 1'b0, data: ~last};
    end
  end
endmodule : slw_mem_model
`default_nettype wire

// [bench/tb_top.sv]
// Bench for the page walker: APB tasks, translation tasks, table builds.
// Assumes the walker's default parameters: max 48, host 46, no etlb.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  localparam logic [51:0] ROOT = 52'h10000;
  localparam logic [63:0] A    = 64'hc0a07123;
  localparam logic [63:0] B    = 64'h80c0a07123;
  logic               clk_sys  = 1'b0;
  logic               reset    = 1'b1;
  logic               psel     = 1'b0;
  logic               penable  = 1'b0;
  logic               pwrite   = 1'b0;
  logic [7:0]         paddr    = 8'h00;
  logic [31:0]        pwdata   = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               req_ready;
  slw_pkg::slw_req_t  req      = '0;
  slw_pkg::slw_rsp_t  rsp;
  slw_pkg::slw_rsp_t  got;
  slw_pkg::slw_mrd_t  mrd;
  slw_pkg::slw_mrsp_t mrsp;
  logic [3:0]         lat      = 4'h0;
  logic [51:0]        err_addr = '1;
  logic [31:0]        rd;
  logic               err;
  int                 bad_count   = 0;
  int                 check_count = 0;

  always #20 clk_sys = ~clk_sys;

  slw_walker dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .req(req),
    .req_ready(req_ready), .rsp(rsp), .mrd(mrd), .mrsp(mrsp));

  slw_mem_model mem (.clk_sys(clk_sys), .reset(reset), .mrd(mrd),
    .mrsp(mrsp), .lat(lat), .err_addr(err_addr));

  task automatic chk(input string what, input logic [63:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    chk("pready", 1, pready);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [63:0] ent(input logic [51:0] b,
                                      input logic [1:0] p, input logic g);
    ent = {12'h0, b[51:12], 4'h0, g, 5'h0, p};
  endfunction : ent

  // Software keeps tables aligned and reserved bits clear
  task automatic build();
    mem.tbl[52'h10008] = ent(ROOT, 2'h3, 1'b0);
    mem.tbl[52'h10018] = ent(52'h20000, 2'h3, 1'b0);
    mem.tbl[52'h20028] = ent(52'h30000, 2'h3, 1'b0);
    mem.tbl[52'h30038] = ent(52'h40000, 2'h3, 1'b0);
  endtask : build

  task automatic try(input logic [1:0] k, input logic [63:0] ia,
                     input logic [51:0] a, input logic [63:0] v,
                     input logic [1:0] fd);
    build();
    mem.tbl[a] = v;
    @(posedge clk_sys);
    while (req_ready !== 1'b1) begin
      @(posedge clk_sys);
    end
    mem.seen.delete();
    req <= '{valid: 1'b1, kind: k, addr: ia};
    @(posedge clk_sys);
    req <= '0;
    while (rsp.valid !== 1'b1) begin
      @(posedge clk_sys);
    end
    got = rsp;
    chk("rsp valid", 1, rsp.valid);
    chk("fault denied", fd, {got.fault, got.denied});
  endtask : try

  task automatic reads(input int n, input logic [51:0] e [4]);
    chk("read count", n, mem.seen.size());
    for (int i = 0; i < n; i++) begin
      chk("read addr", e[i], mem.seen[i]);
    end
  endtask : reads

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(40 * 20000);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, slw_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h27, rd);
    apb(1'b0, slw_pkg::REG_CAP, 32'h0);
    chk("cap", 32'h00072e30, rd);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1'b1, slw_pkg::REG_ROOT_LO, 32'h10000);
    apb(1'b1, slw_pkg::REG_ROOT_HI, 32'h0);
    $display("test registers done");
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h3, 1'b0), 2'b00);
    chk("4k addr", 64'h40123, got.addr);
    chk("4k size", slw_pkg::SIZE_4K, got.size);
    reads(3, '{52'h10018, 52'h20028, 52'h30038, 52'h0});
    apb(1'b0, slw_pkg::REG_RESULT_LO, 32'h0);
    chk("result lo", 32'h40123, rd);
    apb(1'b0, slw_pkg::REG_RESULT_HI, 32'h0);
    chk("result hi", 32'h0, rd);
    apb(1'b0, slw_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h2, rd);
    apb(1'b1, slw_pkg::REG_STATUS, 32'h2);
    apb(1'b0, slw_pkg::REG_STATUS, 32'h0);
    chk("status clear", 32'h0, rd);
    try(2'h0, A, 52'h20028, ent(52'h200000, 2'h3, 1'b1), 2'b00);
    chk("2m addr", 64'h207123, got.addr);
    chk("2m size", slw_pkg::SIZE_2M, got.size);
    reads(2, '{52'h10018, 52'h20028, 52'h0, 52'h0});
    lat <= 4'h4;
    try(2'h0, A, 52'h10018, ent(52'h40000000, 2'h3, 1'b1), 2'b00);
    chk("1g addr", 64'h40a07123, got.addr);
    chk("1g size", slw_pkg::SIZE_1G, got.size);
    reads(1, '{52'h10018, 52'h0, 52'h0, 52'h0});
    try(2'h0, B, 52'h30038, ent(52'h40000, 2'h3, 1'b0), 2'b10);
    reads(0, '{default: '0});
    $display("test walks done");
    lat <= 4'h1;
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h0, 1'b0), 2'b10);
    try(2'h0, A, 52'h20028, ent(52'h800000030000, 2'h3, 1'b0), 2'b10);
    try(2'h0, A, 52'h10018, ent(52'h20000, 2'h3, 1'b0) |
        64'h1 << slw_pkg::ENT_FCOH, 2'b10);
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h3, 1'b0) | 64'h1 << 62,
        2'b10);
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h3, 1'b0) |
        64'h1 << slw_pkg::ENT_FCOH, 2'b00);
    chk("coh leaf addr", 64'h40123, got.addr);
    try(2'h0, A, 52'h20028, ent(52'h201000, 2'h3, 1'b1), 2'b10);
    try(2'h0, A, 52'h10018, ent(52'h40001000, 2'h3, 1'b1), 2'b10);
    err_addr <= 52'h20028;
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h3, 1'b0), 2'b10);
    err_addr <= '1;
    $display("test reserved done");
    try(2'h0, A, 52'h30038, ent(52'h40000, 2'h1, 1'b0), 2'b00);
    try(2'h1, A, 52'h30038, ent(52'h40000, 2'h1, 1'b0), 2'b01);
    apb(1'b0, slw_pkg::REG_STATUS, 32'h0);
    chk("status denied", 32'ha, rd);
    try(2'h2, A, 52'h30038, ent(52'h40000, 2'h2, 1'b0), 2'b01);
    try(2'h2, A, 52'h30038, ent(52'h40000, 2'h3, 1'b0), 2'b00);
    $display("test rights done");
    apb(1'b1, slw_pkg::REG_CTRL, 32'h28);
    lat <= 4'h3;
    try(2'h1, B, 52'h30038, ent(52'h40000, 2'h3, 1'b0), 2'b00);
    chk("4lvl addr", 64'h40123, got.addr);
    reads(4, '{52'h10008, 52'h10018, 52'h20028, 52'h30038});
    try(2'h0, B, 52'h10008, ent(ROOT, 2'h3, 1'b1), 2'b10);
    try(2'h0, A | 64'h1 << 48, 52'h30038, ent(52'h40000, 2'h3, 1'b0),
        2'b10);
    $display("test four level done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
